// ### verilog/iep_pkg.sv
/*
 * Package for the interrupt enable and priority register block: register
 * indices, field positions, reset values and the request carrier types.
 * Assumes a 16-bit register port with word indices and a 10 MHz clock.
 */
package iep_pkg;

    // Register bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register indices on the plain port
    localparam logic [3:0] IDX_ENABLE_4   = 4'h0;
    localparam logic [3:0] IDX_PRIORITY_0 = 4'h1;
    localparam logic [3:0] IDX_PRIORITY_1 = 4'h2;
    localparam logic [3:0] IDX_PRIORITY_2 = 4'h3;
    localparam logic [3:0] IDX_PRIORITY_3 = 4'h4;
    localparam logic [3:0] IDX_PRIORITY_4 = 4'h5;
    localparam logic [3:0] IDX_STATUS     = 4'h6;

    // Enable register 4 bit positions
    localparam int BIT_CHECKSUM_EN = 3;
    localparam int BIT_SERIAL2_ERR = 2;
    localparam int BIT_SERIAL1_ERR = 1;

    // Writable bit masks per register
    localparam logic [15:0] MASK_ENABLE_4   = 16'h000E;
    localparam logic [15:0] MASK_PRIORITY_0 = 16'h7777;
    localparam logic [15:0] MASK_PRIORITY_1 = 16'h7770;
    localparam logic [15:0] MASK_PRIORITY_2 = 16'h7777;
    localparam logic [15:0] MASK_PRIORITY_3 = 16'h0077;
    localparam logic [15:0] MASK_PRIORITY_4 = 16'h7777;

    // Reset values: enables zero, every field binary 100
    localparam logic [15:0] RST_ENABLE_4   = 16'h0000;
    localparam logic [15:0] RST_PRIORITY_0 = 16'h4444;
    localparam logic [15:0] RST_PRIORITY_1 = 16'h4440;
    localparam logic [15:0] RST_PRIORITY_2 = 16'h4444;
    localparam logic [15:0] RST_PRIORITY_3 = 16'h0044;
    localparam logic [15:0] RST_PRIORITY_4 = 16'h4444;

    // Field low-bit positions within a priority register
    localparam int FLD_HI  = 12;
    localparam int FLD_MH  = 8;
    localparam int FLD_ML  = 4;
    localparam int FLD_LO  = 0;
    localparam int PRIO_W  = 3;

    // Priority codes
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_MAX = 3'h7;

    // Source count and source numbering
    localparam int NUM_SRC = 21;
    localparam int SRC_W   = 5;

    // Status register layout
    localparam int ST_LEVEL_LSB  = 8;
    localparam int ST_VALID_BIT  = 15;

    typedef logic [2:0] iep_prio_type;

    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } iep_bus_type;

    // Arbitration result toward the core
    typedef struct packed {
        logic             valid;
        logic [4:0]       source;
        iep_prio_type     level;
    } iep_grant_type;

endpackage

// ### verilog/iep_arbiter.sv
/*
 * Priority arbiter: picks the qualified source with the highest level.
 * Assumes requests and levels are already qualified by enables; ties go
 * to the lowest source number.
 */
module iep_arbiter (
    // Qualified inputs
    input  wire logic [20:0]            req,
    input  wire iep_pkg::iep_prio_type  level [21],
    // Result
    output iep_pkg::iep_grant_type      grant
);

    // Scan all sources, keep the strictly higher level
    always_comb begin
        grant = '0;
        for (int i = 0; i < iep_pkg::NUM_SRC; i++) begin
            // Code zero never wins: source disabled
            if (req[i] && level[i] != iep_pkg::PRIO_OFF &&
                    level[i] > grant.level) begin
                grant.valid  = 1'b1;
                grant.source = iep_pkg::SRC_W'(i);
                grant.level  = level[i];
            end
        end
    end

endmodule

// ### verilog/iep_regs.sv
/*
 * Interrupt enable register 4 and priority registers 0 to 4, with request
 * qualification and a registered arbitration result toward the core.
 * Assumes request lines synchronous to sys_clk and a master that holds
 * strobes one cycle, never both at once.
 */
// Notes on behaviour
// - Code seven is the most urgent level
// - Code zero disables the source entirely
// - Code one is least urgent, linear upward
// - Priority fields reset to binary 100
// - Unimplemented bits always read zero
// - Enable set passes request, resets zero
// - Enable bit 3 gates checksum request
// - Enable bit 2 gates serial two error
// - Enable bit 1 gates serial one error
// - Priority register zero field layout
// - Priority register one field layout
// - Priority register two field layout
// - Priority register three field layout
// - Priority register four field layout
module iep_regs (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    // Peripheral request lines, see source numbering
    input  wire logic [20:0]            src_req,
    input  wire logic                   checksum_gen_req,
    input  wire logic                   serial2_error_req,
    input  wire logic                   serial1_error_req,
    // Gated checksum and serial error requests
    output logic                        checksum_gen_irq,
    output logic                        serial2_error_irq,
    output logic                        serial1_error_irq,
    // Arbitration result toward the core
    output logic                        core_irq_valid,
    output logic      [4:0]             core_irq_source,
    output logic      [2:0]             core_irq_level
);

    // All module state in one struct
    typedef struct packed {
        logic [15:0]            enable_4;    // Enable register 4
        logic [15:0]            prio_0;      // Priority register 0
        logic [15:0]            prio_1;      // Priority register 1
        logic [15:0]            prio_2;      // Priority register 2
        logic [15:0]            prio_3;      // Priority register 3
        logic [15:0]            prio_4;      // Priority register 4
        logic [15:0]            rdata;       // Read data, one cycle late
        iep_pkg::iep_grant_type grant;       // Registered winner
        logic [2:0]             err_gate;    // Gated error requests
    } iep_state_type;

    iep_state_type              state;       // Current state
    iep_state_type              next_state;  // Next state
    iep_pkg::iep_bus_type       bus;         // Bundled bus request
    iep_pkg::iep_prio_type      level [21];  // Per-source level
    iep_pkg::iep_grant_type     win;         // Combinational winner

    // Extract a three-bit field at a low-bit position
    function automatic iep_pkg::iep_prio_type field(
            input logic [15:0] r, input int lsb);
        field = r[lsb +: iep_pkg::PRIO_W];
    endfunction

    // Merge write data under a writable mask
    function automatic logic [15:0] masked(
            input logic [15:0] wd, input logic [15:0] mask);
        masked = wd & mask;
    endfunction

    // Bundle the bus signals
    assign bus = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

    // Source numbering: field positions per register
    always_comb begin
        // Priority register 0: timer1, compare1, capture1, ext0
        level[0]  = field(state.prio_0, iep_pkg::FLD_HI);
        level[1]  = field(state.prio_0, iep_pkg::FLD_MH);
        level[2]  = field(state.prio_0, iep_pkg::FLD_ML);
        level[3]  = field(state.prio_0, iep_pkg::FLD_LO);
        // Priority register 1: timer2, compare2, capture2
        level[4]  = field(state.prio_1, iep_pkg::FLD_HI);
        level[5]  = field(state.prio_1, iep_pkg::FLD_MH);
        level[6]  = field(state.prio_1, iep_pkg::FLD_ML);
        // Priority register 2: serial1 rx, spi1 event, spi1 fault, timer3
        level[7]  = field(state.prio_2, iep_pkg::FLD_HI);
        level[8]  = field(state.prio_2, iep_pkg::FLD_MH);
        level[9]  = field(state.prio_2, iep_pkg::FLD_ML);
        level[10] = field(state.prio_2, iep_pkg::FLD_LO);
        // Priority register 3: adc done, serial1 tx
        level[11] = field(state.prio_3, iep_pkg::FLD_ML);
        level[12] = field(state.prio_3, iep_pkg::FLD_LO);
        // Priority register 4: pin change, comparator, i2c master, slave
        level[13] = field(state.prio_4, iep_pkg::FLD_HI);
        level[14] = field(state.prio_4, iep_pkg::FLD_MH);
        level[15] = field(state.prio_4, iep_pkg::FLD_ML);
        level[16] = field(state.prio_4, iep_pkg::FLD_LO);
        // Sources whose level lives outside this block: fixed level 1
        for (int i = 17; i < iep_pkg::NUM_SRC; i++) begin
            level[i] = 3'h1;
        end
    end

    // Winner among qualified requests
    iep_arbiter u_arbiter (
        .req   (src_req),
        .level (level),
        .grant (win)
    );

    // Next-state logic: register writes, reads, gating, grant
    always_comb begin
        next_state = state;
        // Register writes, writable bits only
        if (bus.wr) begin
            unique case (bus.addr)
                iep_pkg::IDX_ENABLE_4:
                    next_state.enable_4 = masked(bus.wdata,
                        iep_pkg::MASK_ENABLE_4);
                iep_pkg::IDX_PRIORITY_0:
                    next_state.prio_0 = masked(bus.wdata,
                        iep_pkg::MASK_PRIORITY_0);
                iep_pkg::IDX_PRIORITY_1:
                    next_state.prio_1 = masked(bus.wdata,
                        iep_pkg::MASK_PRIORITY_1);
                iep_pkg::IDX_PRIORITY_2:
                    next_state.prio_2 = masked(bus.wdata,
                        iep_pkg::MASK_PRIORITY_2);
                iep_pkg::IDX_PRIORITY_3:
                    next_state.prio_3 = masked(bus.wdata,
                        iep_pkg::MASK_PRIORITY_3);
                iep_pkg::IDX_PRIORITY_4:
                    next_state.prio_4 = masked(bus.wdata,
                        iep_pkg::MASK_PRIORITY_4);
                default: ; // Status and unmapped: writes ignored
            endcase
        end
        // Read data: valid only in the cycle after the strobe
        next_state.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                iep_pkg::IDX_ENABLE_4:   next_state.rdata = state.enable_4;
                iep_pkg::IDX_PRIORITY_0: next_state.rdata = state.prio_0;
                iep_pkg::IDX_PRIORITY_1: next_state.rdata = state.prio_1;
                iep_pkg::IDX_PRIORITY_2: next_state.rdata = state.prio_2;
                iep_pkg::IDX_PRIORITY_3: next_state.rdata = state.prio_3;
                iep_pkg::IDX_PRIORITY_4: next_state.rdata = state.prio_4;
                iep_pkg::IDX_STATUS: begin
                    // Current winner: valid, level, source
                    next_state.rdata[iep_pkg::ST_VALID_BIT] =
                        state.grant.valid;
                    next_state.rdata[iep_pkg::ST_LEVEL_LSB +: 3] =
                        state.grant.level;
                    next_state.rdata[4:0] = state.grant.source;
                end
                default: next_state.rdata = '0; // Unmapped reads zero
            endcase
        end
        // Enable gates on the checksum and serial error requests
        next_state.err_gate[2] = checksum_gen_req &
            state.enable_4[iep_pkg::BIT_CHECKSUM_EN];
        next_state.err_gate[1] = serial2_error_req &
            state.enable_4[iep_pkg::BIT_SERIAL2_ERR];
        next_state.err_gate[0] = serial1_error_req &
            state.enable_4[iep_pkg::BIT_SERIAL1_ERR];
        // Register the arbitration winner
        next_state.grant = win;
    end

    // State register with reset values
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state          <= '0;
            state.enable_4 <= iep_pkg::RST_ENABLE_4;
            state.prio_0   <= iep_pkg::RST_PRIORITY_0;
            state.prio_1   <= iep_pkg::RST_PRIORITY_1;
            state.prio_2   <= iep_pkg::RST_PRIORITY_2;
            state.prio_3   <= iep_pkg::RST_PRIORITY_3;
            state.prio_4   <= iep_pkg::RST_PRIORITY_4;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata         = state.rdata;
    assign checksum_gen_irq  = state.err_gate[2];
    assign serial2_error_irq = state.err_gate[1];
    assign serial1_error_irq = state.err_gate[0];
    assign core_irq_valid    = state.grant.valid;
    assign core_irq_source   = state.grant.source;
    assign core_irq_level    = state.grant.level;

endmodule

// ### test/iep_regs_props.sv
/* Checker for the enable and priority register block.
   Bound to iep_regs; sees only its ports, one clock domain. */
module iep_regs_props (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Requests in
    input wire logic [20:0] src_req,
    input wire logic        checksum_gen_req,
    input wire logic        serial2_error_req,
    input wire logic        serial1_error_req,
    // Results out
    input wire logic        checksum_gen_irq,
    input wire logic        serial2_error_irq,
    input wire logic        serial1_error_irq,
    input wire logic        core_irq_valid,
    input wire logic [4:0]  core_irq_source,
    input wire logic [2:0]  core_irq_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Read data shows only in the cycle after a read
    a_rdata_idle: assert property (!$past(reg_rd)
        |-> reg_rdata == 16'h0)
        else $error("read data outside read cycle");
    // Unimplemented bits of the enable register
    a_en_unimp: assert property ($past(reg_rd && reg_addr == 4'h0)
        |-> reg_rdata[15:4] == 12'h0 && !reg_rdata[0])
        else $error("enable register spare bits set");
    // Unimplemented bits of priority register one
    a_p1_unimp: assert property ($past(reg_rd && reg_addr == 4'h2)
        |-> reg_rdata[3:0] == 4'h0 && !reg_rdata[15])
        else $error("priority one spare bits set");
    // Unimplemented bits of priority register three
    a_p3_unimp: assert property ($past(reg_rd && reg_addr == 4'h4)
        |-> reg_rdata[15:7] == 9'h0)
        else $error("priority three spare bits set");
    // Gated error lines need their request one cycle before
    a_chk_gate: assert property (checksum_gen_irq
        |-> $past(checksum_gen_req))
        else $error("checksum irq without request");
    a_ser2_gate: assert property (serial2_error_irq
        |-> $past(serial2_error_req))
        else $error("serial two irq without request");
    a_ser1_gate: assert property (serial1_error_irq
        |-> $past(serial1_error_req))
        else $error("serial one irq without request");
    // A winner has a live level and a real source
    a_level_live: assert property (core_irq_valid
        |-> core_irq_level != 3'h0 && core_irq_source < 5'd21)
        else $error("winner with level zero");
    // The winner was requesting, and no request means no winner
    // Index the request word of the last cycle with the current winner
    a_winner_req: assert property (core_irq_valid
        |-> ($past(src_req) & (21'h1 << core_irq_source)) != 21'h0)
        else $error("winner not requesting");
    a_no_req: assert property ($past(src_req) == 21'h0 |-> !core_irq_valid)
        else $error("winner with no request");
    // Fixed sources sit at the least urgent level
    a_fixed_lvl: assert property (core_irq_valid
        && core_irq_source > 5'h10 |-> core_irq_level == 3'h1)
        else $error("fixed source level wrong");
    // Main scenarios reached
    c_top: cover property (core_irq_valid && core_irq_level == 3'h7);
    c_chk: cover property (checksum_gen_irq);
    c_read: cover property ($past(reg_rd) && reg_rdata != 16'h0);
endmodule

bind iep_regs iep_regs_props u_props (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .src_req, .checksum_gen_req,
    .serial2_error_req, .serial1_error_req, .checksum_gen_irq,
    .serial2_error_irq, .serial1_error_irq, .core_irq_valid,
    .core_irq_source, .core_irq_level);

// ### test/iep_src_model.sv
/* Peripheral request sources facing the block.
   The bench sets wanted levels; lines move just after a clock edge. */
module iep_src_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Wanted levels
    input  wire logic [20:0] want_req,
    input  wire logic [2:0]  want_err,
    // Lines to the block: checksum, serial two, serial one
    output logic      [20:0] src_req,
    output logic      [2:0]  err_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Requests launch off the clock edge, quiet in reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            src_req <= 21'h0;
            err_req <= 3'h0;
        end else begin
            src_req <= want_req;
            err_req <= want_err;
        end
    end
endmodule

// ### test/tb.sv
/* Self-checking bench for iep_regs with the request source model.
   Assumes a 10 MHz clock and register indices 0 to 6. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst, reg_wr, reg_rd, core_irq_valid;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [20:0] want_req, src_req;
    logic [2:0]  want_err, err_req, err_irq, core_irq_level;
    logic [4:0]  core_irq_source;
    int          fail_count = 0;
    int          num_checks = 0;
    // Rows: index, reset value, value after writing all ones
    logic [35:0] rows [8] = '{36'h00000000E, 36'h144447777, 36'h244407770,
        36'h344447777, 36'h400440077, 36'h544447777, 36'h700000000,
        36'hF00000000};
    // Field of each source: register index, low bit
    logic [7:0]  fld [17] = '{8'h1C, 8'h18, 8'h14, 8'h10, 8'h2C, 8'h28,
        8'h24, 8'h3C, 8'h38, 8'h34, 8'h30, 8'h44, 8'h40, 8'h5C, 8'h58,
        8'h54, 8'h50};

    always #50 sys_clk = ~sys_clk;

    iep_src_model src (.sys_clk, .rst, .want_req, .want_err, .src_req,
        .err_req);
    iep_regs uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .src_req, .checksum_gen_req(err_req[2]),
        .serial2_error_req(err_req[1]), .serial1_error_req(err_req[0]),
        .checksum_gen_irq(err_irq[2]), .serial2_error_irq(err_irq[1]),
        .serial1_error_irq(err_irq[0]), .core_irq_valid, .core_irq_source,
        .core_irq_level);

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read, data checked in the next cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Set request lines, check {valid, source, level}
    task automatic grant(input logic [20:0] q, input logic [8:0] e);
        @(posedge sys_clk);
        want_req <= q;
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h0, core_irq_valid, core_irq_source, core_irq_level},
            {7'h0, e});
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #1ms;
        fail_count++;
        test_done;
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        want_req = 21'h0;
        want_err = 3'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset value, all-ones readback, then clear
        foreach (rows[i]) begin
            rd(rows[i][35:32], rows[i][31:16]);
            wr(rows[i][35:32], 16'hFFFF);
            rd(rows[i][35:32],
                rows[i][15:0]);
            wr(rows[i][35:32], 16'h0000);
        end
        // All fields zero: nothing wins
        grant(21'h1FFFF, 9'h0);
        // Each field alone at level seven
        foreach (fld[s]) begin
            wr(fld[s][7:4], 16'h7 << fld[s][3:0]);
            grant(21'h1FFFF,
                {1'b1, 5'(s), 3'h7});
            wr(fld[s][7:4], 16'h0000);
        end
        // Every code on one source against a fixed level-one source
        for (int c = 0; c < 8; c++) begin
            wr(4'h1, 16'(c));
            // Code zero: fixed source 17 at level one takes over
            grant(21'h20008,
                c ? {1'b1, 5'h03, 3'(c)} : 9'h189);
        end
        // Higher level beats lower
        wr(4'h1, 16'h5006);
        grant(21'h0000F, {1'b1, 5'd3, 3'h6});
        // Status word: valid, level six, source three
        rd(4'h6, 16'h8603);
        // Each enable bit alone with all error lines high
        for (int b = 0; b < 4; b++) begin
            wr(4'h0, 16'(b ? 1 << b : 0));
            want_err <= 3'h7;
            repeat (3) @(posedge sys_clk);
            #1 chk({13'h0, err_irq},
                {13'h0, 3'(b ? 1 << (b - 1) : 0)});
        end
        // Second reset in mid-run
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(4'h1, 16'h4444);
        rd(4'h0, 16'h0000);
        grant(21'h20008, {1'b1, 5'd3, 3'h4});
        test_done;
    end
endmodule
